/* hw/ser_pkg.sv */
// ser_pkg: constants and types shared by the status and event reporting block.
// assumes: one clock domain; all field positions use the documented bit weights.
package ser_pkg;
   // widths and depths
   localparam int SER_CODE_W   = 16;                // signed event code width
   localparam int SER_EQ_DEPTH = 10;                // error/event queue entries
   localparam int SER_OQ_DEPTH = 4;                 // output queue entries

   typedef logic signed [SER_CODE_W-1:0] ser_code_t;

   // host command set carried on the command port
   typedef enum logic [3:0] {
      SER_CMD_NONE,
      SER_CMD_SRE_WR,
      SER_CMD_SRE_Q,
      SER_CMD_ESE_WR,
      SER_CMD_ESE_Q,
      SER_CMD_ESR_Q,
      SER_CMD_STB_Q,
      SER_CMD_OPC,
      SER_CMD_ERR_Q
   } ser_cmd_t;

   // status byte field positions
   localparam int SER_STB_EQNE = 2;                 // error/event queue not empty
   localparam int SER_STB_MAV  = 4;                 // message available
   localparam int SER_STB_ESB  = 5;                 // event status summary
   localparam int SER_STB_MSS  = 6;                 // master summary / request service

   // standard event status field positions
   localparam int SER_ESR_OPC  = 0;                 // operation complete
   localparam int SER_ESR_QYE  = 2;                 // query error
   localparam int SER_ESR_EXE  = 4;                 // execution error
   localparam int SER_ESR_CME  = 5;                 // command error
   localparam int SER_ESR_PON  = 7;                 // power on

   // implemented bits of each register
   localparam logic [7:0] SER_SRE_MASK  = 8'h34;
   localparam logic [7:0] SER_ESE_MASK  = 8'hB5;
   localparam logic [7:0] SER_ESR_MASK  = 8'hB5;

   // values after reset
   localparam logic [7:0] SER_SRE_RESET = 8'h00;
   localparam logic [7:0] SER_ESE_RESET = 8'h00;
   localparam logic [7:0] SER_ESR_RESET = 8'h80;   // power on recorded

   // special codes
   localparam ser_code_t  SER_CODE_OVF    = -16'sd350; // queue overflow
   localparam ser_code_t  SER_CODE_NOERR  = 16'sd0;    // empty queue answer
endpackage

/* hw/ser_eq_if.sv */
// ser_eq_if: link between the reporting core and its error/event queue.
// assumes: both ends on clk_sys; push and pop are one-cycle strobes.
interface ser_eq_if;
   import ser_pkg::*;
   logic      push;                                 // enqueue strobe
   ser_code_t pushCode;                             // code to enqueue
   logic      pop;                                  // dequeue strobe
   ser_code_t headCode;                             // oldest entry
   logic      notEmpty;                             // queue holds entries
   logic      overflow;                             // pulse: push met full queue
   modport owner (output push, pushCode, pop, input headCode, notEmpty, overflow);
   modport queue (input push, pushCode, pop, output headCode, notEmpty, overflow);
endinterface

/* hw/ser_err_queue.sv */
// ser_err_queue: first-in first-out store of event codes, head at entry 0.
// assumes: synchronous active-low reset from the top; one push and one pop per cycle.
module ser_err_queue #(
   parameter int DEPTH = ser_pkg::SER_EQ_DEPTH      // entries held
) (
   input  wire logic clk_sys,                        // system clock
   input  wire logic rstN,                           // synchronised reset, active low
   ser_eq_if.queue   eq                              // queue side of the link
);
   import ser_pkg::*;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_C   = CW'(1);

   logic      [CW-1:0] cnt_r;
   logic      [CW-1:0] cnt_nxt;
   ser_code_t          q_r   [DEPTH];
   ser_code_t          q_nxt [DEPTH];
   logic               ovf_r;

   // strobe qualification
   wire logic          isFull   = (cnt_r == DEPTH_C);
   wire logic          popOk    = eq.pop && (cnt_r != '0);
   wire logic          pushOk   = eq.push && (!isFull || popOk);
   wire logic          pushLost = eq.push && isFull && !popOk;
   wire logic [CW-1:0] wrIdx    = popOk ? cnt_r - ONE_C : cnt_r;

   assign cnt_nxt     = cnt_r + (pushOk ? ONE_C : '0) - (popOk ? ONE_C : '0);
   assign eq.headCode = q_r[0];
   assign eq.notEmpty = (cnt_r != '0);
   assign eq.overflow = ovf_r;

   // per-entry next value: write, shift on pop, or overflow marker in last slot
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         wire ser_code_t shifted = (gi == DEPTH - 1) ? SER_CODE_NOERR : q_r[(gi + 1) % DEPTH];
         // [RQ17] fifo order kept
         // [RQ22] overflow replaces newest
         assign q_nxt[gi] = (pushOk && wrIdx == CW'(gi)) ? eq.pushCode :
                            (pushLost && gi == DEPTH - 1) ? SER_CODE_OVF :
                            popOk ? shifted : q_r[gi];
         always_ff @(posedge clk_sys) begin
            if (!rstN) q_r[gi] <= SER_CODE_NOERR;
            else       q_r[gi] <= q_nxt[gi];
         end
      end
   endgenerate

   // occupancy and overflow pulse
   always_ff @(posedge clk_sys) begin
      if (!rstN) begin
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ovf_r <= pushLost;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstN);

   chk_eq_never_over: assert property (cnt_r <= DEPTH_C) // [RQ17]
      else $error("error queue count above depth");
   chk_eq_ovf_mark: assert property (pushLost |=> q_r[DEPTH-1] == SER_CODE_OVF) // [RQ22]
      else $error("overflow code not placed in last slot");
endmodule

/* hw/ser_top.sv */
// ser_top: status byte, service request, event status registers, output queue.
// assumes: host commands arrive as one-cycle strobes on clk_sys; event inputs come
// from logic on the same clock; arst_n may be asynchronous to clk_sys.
import ser_pkg::*;

// Overview of operation
// [RQ1] Keep service request enable mask; write by command, query returns its value.
// [RQ2] Enable bit 2 requests service when a message enters the error queue.
// [RQ3] Enable bit 4 requests service when a message enters the output queue.
// [RQ4] Enable bit 5 requests service when the event summary bit sets.
// [RQ5] Status bit 6 sets when any enabled status bit is set.
// [RQ6] Reading event status returns its value then clears all bits.
// [RQ7] Operation complete bit sets once pending work ends after the request.
// [RQ8] Query error bit sets when output queue data is lost.
// [RQ9] Execution error bit sets on a fault while executing.
// [RQ10] Command error bit sets on a fault while parsing.
// [RQ11] Power on bit records that the device was powered up.
// [RQ12] Keep event enable mask selecting events summarised in status bit 5.
// [RQ13] Enable bits 0,2,4,5,7 each pass the same event bit to status bit 5.
// [RQ14] Event enable query returns the mask value.
// [RQ15] Every query answer goes into the output queue for the host.
// [RQ16] Error query returns and removes the oldest queued event code.
// [RQ17] Error queue holds ten entries in first-in first-out order.
// [RQ18] Unused mask and event bits read zero and feed no summary.
// [RQ19] Status bits show queue not empty, message available, event summary.
// [RQ20] Message available sets when an answer is written to the output queue.
// [RQ21] An enabled set status bit raises master summary and service request.
// [RQ22] Queue overflow on either queue reports code -350.
module ser_top #(
   parameter int OQ_DEPTH = ser_pkg::SER_OQ_DEPTH    // output queue entries
) (
   input  wire  logic               clk_sys,         // system clock, 25 MHz
   input  wire  logic               arst_n,          // asynchronous reset, active low
   input  wire  logic               cmdValid,        // command strobe
   input  wire  ser_pkg::ser_cmd_t  cmdOp,           // command or query kind
   input  wire  logic [7:0]         cmdData,         // mask value for write commands
   input  wire  logic               opsIdle,         // no operation pending
   input  wire  logic               execErr,         // execution fault strobe
   input  wire  logic               cmdErr,          // parse fault strobe
   input  wire  ser_pkg::ser_code_t errCode,         // code queued with a fault
   input  wire  logic               respRead,        // host takes head answer
   output logic                     respValid,       // output queue not empty
   output ser_pkg::ser_code_t       respData,        // head answer
   output logic [7:0]               statusByte,      // status byte image
   output logic                     serviceRequest   // request service level
);
   import ser_pkg::*;
   localparam int OCW = $clog2(OQ_DEPTH + 1);
   localparam logic [OCW-1:0] OQ_FULL_C = OCW'(OQ_DEPTH);
   localparam logic [OCW-1:0] OQ_ONE_C  = OCW'(1);

   // command decode helper, used for every kind except SER_CMD_NONE
   function automatic logic cmdIs(input logic v, input ser_cmd_t op, input ser_cmd_t want);
      cmdIs = v && (op == want);
   endfunction

   logic [1:0]      rstPipe_r;
   logic            rstN;
   logic [7:0]      sre_r;
   logic [7:0]      ese_r;
   logic [7:0]      esr_r;
   logic [7:0]      esr_nxt;
   logic            opcPend_r;
   logic            ovfPend_r;
   logic [OCW-1:0]  oqCnt_r;
   logic [OCW-1:0]  oqCnt_nxt;
   ser_code_t       oq_r   [OQ_DEPTH];
   ser_code_t       oq_nxt [OQ_DEPTH];
   logic [7:0]      statusByte_r;
   logic            srq_r;
   logic            respValid_r;

   ser_eq_if eqLink ();

   // reset release through two flip-flops
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) rstPipe_r <= 2'b00;
      else         rstPipe_r <= {rstPipe_r[0], 1'b1};
   end
   assign rstN = rstPipe_r[1];

   // command decode
   wire logic isSreWr = cmdIs(cmdValid, cmdOp, SER_CMD_SRE_WR);
   wire logic isSreQ  = cmdIs(cmdValid, cmdOp, SER_CMD_SRE_Q);
   wire logic isEseWr = cmdIs(cmdValid, cmdOp, SER_CMD_ESE_WR);
   wire logic isEseQ  = cmdIs(cmdValid, cmdOp, SER_CMD_ESE_Q);
   wire logic isEsrQ  = cmdIs(cmdValid, cmdOp, SER_CMD_ESR_Q);
   wire logic isStbQ  = cmdIs(cmdValid, cmdOp, SER_CMD_STB_Q);
   wire logic isOpc   = cmdIs(cmdValid, cmdOp, SER_CMD_OPC);
   wire logic isErrQ  = cmdIs(cmdValid, cmdOp, SER_CMD_ERR_Q);
   wire logic isQuery = isSreQ || isEseQ || isEsrQ || isStbQ || isErrQ;

   // [RQ19] status byte fields
   // [RQ13] enabled event summary
   wire logic eqNotEmpty = eqLink.notEmpty;
   wire logic msgAvail   = (oqCnt_r != '0);
   wire logic evtSum     = |(esr_r & ese_r & SER_ESE_MASK);
   wire logic [7:0] stbLow = 8'((eqNotEmpty << SER_STB_EQNE) | (msgAvail << SER_STB_MAV)
                                | (evtSum << SER_STB_ESB));
   // [RQ5] master summary from enabled bits
   // [RQ2] [RQ3] [RQ4] mask gates each source
   wire logic       mss    = |(stbLow & sre_r & SER_SRE_MASK);
   wire logic [7:0] stbCur = stbLow | 8'(mss << SER_STB_MSS);

   // [RQ15] query answer selection
   // [RQ1] [RQ14] mask readback
   // [RQ16] oldest event code, zero when empty
   wire ser_code_t queryWord =
      isSreQ ? ser_code_t'({8'h00, sre_r}) :
      isEseQ ? ser_code_t'({8'h00, ese_r}) :
      isEsrQ ? ser_code_t'({8'h00, esr_r}) :
      isStbQ ? ser_code_t'({8'h00, stbCur}) :
      (eqNotEmpty ? eqLink.headCode : SER_CODE_NOERR);

   // output queue control; head sits in entry 0
   wire logic           oqPop   = respRead && msgAvail;
   wire logic           oqFull  = (oqCnt_r == OQ_FULL_C);
   wire logic           oqPush  = isQuery && (!oqFull || oqPop);
   wire logic           oqLost  = isQuery && oqFull && !oqPop;
   wire logic [OCW-1:0] oqWrIdx = oqPop ? oqCnt_r - OQ_ONE_C : oqCnt_r;
   assign oqCnt_nxt = oqCnt_r + (oqPush ? OQ_ONE_C : '0) - (oqPop ? OQ_ONE_C : '0);

   // [RQ15] [RQ20] output queue entries
   genvar gi;
   generate
      for (gi = 0; gi < OQ_DEPTH; gi++) begin : g_oq
         wire ser_code_t shifted = (gi == OQ_DEPTH - 1) ? SER_CODE_NOERR
                                                        : oq_r[(gi + 1) % OQ_DEPTH];
         assign oq_nxt[gi] = (oqPush && oqWrIdx == OCW'(gi)) ? queryWord :
                             oqPop ? shifted : oq_r[gi];
         always_ff @(posedge clk_sys) begin
            if (!rstN) oq_r[gi] <= SER_CODE_NOERR;
            else       oq_r[gi] <= oq_nxt[gi];
         end
      end
   endgenerate

   // error queue feed: a fault strobe has priority, a lost answer waits a cycle
   wire logic faultIn  = execErr || cmdErr;
   wire logic ovfPush  = ovfPend_r && !faultIn;
   // [RQ22] lost output reported as overflow code
   assign eqLink.push     = faultIn || ovfPush;
   assign eqLink.pushCode = faultIn ? errCode : SER_CODE_OVF;
   // [RQ16] error query removes the entry
   assign eqLink.pop      = isErrQ;

   // [RQ7] completion seen after the request
   wire logic opcHit = opcPend_r && opsIdle;

   // [RQ8] [RQ9] [RQ10] event bits to set this cycle
   wire logic [7:0] esrSet = 8'((opcHit << SER_ESR_OPC) | (oqLost << SER_ESR_QYE)
                                | (execErr << SER_ESR_EXE) | (cmdErr << SER_ESR_CME));
   // [RQ6] read clears, a new event in the same cycle survives
   // [RQ18] unused bits held at zero
   assign esr_nxt = ((isEsrQ ? 8'h00 : esr_r) | esrSet) & SER_ESR_MASK;

   // mask registers
   // [RQ1] [RQ12] [RQ18] host writes masks, unused bits dropped
   always_ff @(posedge clk_sys) begin
      if (!rstN) begin
         sre_r <= SER_SRE_RESET;
         ese_r <= SER_ESE_RESET;
      end else begin
         if (isSreWr) sre_r <= cmdData & SER_SRE_MASK;
         if (isEseWr) ese_r <= cmdData & SER_ESE_MASK;
      end
   end

   // [RQ11] power on recorded by the reset value
   always_ff @(posedge clk_sys) begin
      if (!rstN) esr_r <= SER_ESR_RESET;
      else       esr_r <= esr_nxt;
   end

   // pending flags: set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!rstN) begin
         opcPend_r <= 1'b0;
         ovfPend_r <= 1'b0;
      end else begin
         opcPend_r <= isOpc || (opcPend_r && !opsIdle);
         ovfPend_r <= oqLost || (ovfPend_r && !ovfPush);
      end
   end

   // queue occupancy and registered outputs
   // [RQ21] service request follows master summary
   always_ff @(posedge clk_sys) begin
      if (!rstN) begin
         oqCnt_r      <= '0;
         statusByte_r <= 8'h00;
         srq_r        <= 1'b0;
         respValid_r  <= 1'b0;
      end else begin
         oqCnt_r      <= oqCnt_nxt;
         statusByte_r <= stbCur;
         srq_r        <= mss;
         respValid_r  <= (oqCnt_nxt != '0);
      end
   end

   assign respValid      = respValid_r;
   assign respData       = oq_r[0];
   assign statusByte     = statusByte_r;
   assign serviceRequest = srq_r;

   // [RQ17] ten-entry error/event queue
   ser_err_queue #(
      .DEPTH (SER_EQ_DEPTH)
   ) u_eq (
      .clk_sys (clk_sys),
      .rstN    (rstN),
      .eq      (eqLink.queue)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstN);

   sequence seqStbLag;
      ##1 1'b1 ##1 1'b1;
   endsequence
   sequence seqEqFilled;
      eqLink.push && !eqLink.pop;
   endsequence

   // mask writes and event bits
   chk_sre_write_mask: assert property ( // [RQ1]
      isSreWr |=> sre_r == ($past(cmdData) & SER_SRE_MASK))
      else $error("enable mask not written");
   chk_ese_write_mask: assert property ( // [RQ12]
      isEseWr |=> ese_r == ($past(cmdData) & SER_ESE_MASK))
      else $error("event enable mask not written");
   chk_esr_read_clear: assert property (isEsrQ && esrSet == 8'h00 |=> esr_r == 8'h00) // [RQ6]
      else $error("event status not cleared by read");
   chk_opc_sets_bit: assert property ( // [RQ7]
      opcHit |=> esr_r[SER_ESR_OPC] && opcPend_r == $past(isOpc))
      else $error("operation complete not recorded");
   chk_lost_query_err: assert property (oqLost |=> esr_r[SER_ESR_QYE] && ovfPend_r) // [RQ8]
      else $error("query error not recorded");
   chk_exec_err_bit: assert property (execErr |=> esr_r[SER_ESR_EXE]) // [RQ9]
      else $error("execution error not recorded");
   chk_cmd_err_bit: assert property (cmdErr |=> esr_r[SER_ESR_CME]) // [RQ10]
      else $error("command error not recorded");
   chk_esb_to_stb: assert property ( // [RQ13]
      (esr_r & ese_r) != 8'h00 |=> statusByte_r[SER_STB_ESB])
      else $error("event summary missing in status byte");
   chk_unused_zero: assert property ( // [RQ18]
      ((sre_r & ~SER_SRE_MASK) | (ese_r & ~SER_ESE_MASK) | (esr_r & ~SER_ESR_MASK)) == 8'h00)
      else $error("unused bit set");
   chk_pon_after_reset: assert property ( // [RQ11]
      $rose(rstN) |-> esr_r == SER_ESR_RESET)
      else $error("power on not recorded");
   chk_opc_arms: assert property ( // [RQ7]
      isOpc |=> opcPend_r)
      else $error("operation complete not armed");

   // status byte and service request
   chk_mav_after_push: assert property ( // [RQ20]
      oqPush |-> seqStbLag ##0 statusByte_r[SER_STB_MAV])
      else $error("message available not shown");
   chk_eqne_after_push: assert property ( // [RQ19]
      seqEqFilled |-> seqStbLag ##0 statusByte_r[SER_STB_EQNE])
      else $error("queue not empty not shown");
   chk_srq_follows: assert property ( // [RQ21]
      (stbLow & sre_r) != 8'h00 |=> serviceRequest && statusByte[SER_STB_MSS])
      else $error("service request not raised");
   chk_srq_drops: assert property ((stbLow & sre_r) == 8'h00 |=> !serviceRequest) // [RQ5]
      else $error("service request without enabled cause");
   chk_eq_srq: assert property ( // [RQ2]
      seqEqFilled ##0 (sre_r[SER_STB_EQNE] && !isSreWr) |-> seqStbLag ##0 serviceRequest)
      else $error("error queue entry raised no request");
   chk_oq_srq: assert property ( // [RQ3]
      oqPush && sre_r[SER_STB_MAV] && !isSreWr |-> seqStbLag ##0 serviceRequest)
      else $error("output queue entry raised no request");
   chk_esb_srq: assert property ( // [RQ4]
      evtSum && sre_r[SER_STB_ESB] |=> serviceRequest)
      else $error("event summary raised no request");

   // output queue bounds and answer contents
   chk_oq_never_over: assert property ( // [RQ15]
      oqCnt_r <= OQ_FULL_C)
      else $error("output queue count above depth");
   chk_oq_takes_query: assert property ( // [RQ15]
      isQuery && !oqFull |=> msgAvail)
      else $error("query answer not queued");
   chk_resp_valid_lvl: assert property ( // [RQ20]
      respValid == msgAvail)
      else $error("answer valid disagrees with queue");
   chk_sre_answer: assert property ( // [RQ1]
      isSreQ && !msgAvail |=> respData == 16'($past(sre_r)))
      else $error("enable mask answer wrong");
   chk_ese_answer: assert property ( // [RQ14]
      isEseQ && !msgAvail |=> respData == 16'($past(ese_r)))
      else $error("event enable answer wrong");
   chk_esr_answer: assert property ( // [RQ6]
      isEsrQ && !msgAvail |=> respData == 16'($past(esr_r)))
      else $error("event status answer wrong");
   chk_stb_answer: assert property ( // [RQ19]
      isStbQ && !msgAvail |=> respData == 16'($past(stbCur)))
      else $error("status byte answer wrong");
   chk_err_answer: assert property ( // [RQ16]
      isErrQ && eqNotEmpty && !msgAvail |=> respData == $past(eqLink.headCode))
      else $error("oldest event code not answered");
   chk_err_empty: assert property ( // [RQ16]
      isErrQ && !eqNotEmpty && !msgAvail |=> respData == SER_CODE_NOERR)
      else $error("empty error queue answer not zero");

   // error queue feed
   chk_fault_queued: assert property ( // [RQ9]
      faultIn |-> eqLink.push && eqLink.pushCode == errCode)
      else $error("fault code not queued");
   chk_ovf_reported: assert property ( // [RQ22]
      ovfPend_r && !faultIn |-> eqLink.push && eqLink.pushCode == SER_CODE_OVF)
      else $error("lost answer not reported");
endmodule

/* verification/ser_host_model.sv */
// ser_host_model: host side of the command port, issuing commands and taking answers.
// assumes: ser_top on the same clk_sys; drives only at falling edges.
module ser_host_model (
   input  wire logic  clk_sys,                 // system clock
   input  wire logic  respValid,               // answer waiting at the head
   output logic       cmdValid,                // command strobe
   output ser_pkg::ser_cmd_t cmdOp,            // command kind
   output logic [7:0] cmdData,                 // mask value
   output logic       respRead                 // take head answer
);
   timeunit 1ns;
   timeprecision 1ps;
   import ser_pkg::*;

   logic slow;                                 // stall answer reads when high

   // idle levels at time zero
   initial begin
      cmdValid = 1'b0;
      cmdOp    = SER_CMD_NONE;
      cmdData  = 8'h00;
      respRead = 1'b0;
      slow     = 1'b0;
   end

   // take one answer per cycle unless stalled; only when one is waiting
   always @(negedge clk_sys) begin
      respRead <= (respValid === 1'b1) && !slow;
   end

   // one-cycle command strobe; data is scrambled once released
   task automatic issue(input ser_cmd_t op, input logic [7:0] data);
      @(negedge clk_sys);
      cmdValid = 1'b1;
      cmdOp    = op;
      cmdData  = data;
      @(negedge clk_sys);
      cmdValid = 1'b0;
      cmdOp    = SER_CMD_NONE;
      cmdData  = ~data;
   endtask
endmodule

/* verification/ser_top_bench.sv */
// ser_top_bench: self-checking bench for the status and event reporting block.
// assumes: ser_host_model drives the command port; the bench drives fault and idle inputs.
module ser_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ser_pkg::*;

   logic       clk_sys, arst_n, opsIdle, execErr, cmdErr, respRead, cmdValid;
   logic       respValid, serviceRequest;
   ser_code_t  errCode, respData;
   ser_cmd_t   cmdOp;
   logic [7:0] cmdData, statusByte, v, w;
   int         n_mismatch, checked, cycleCount, seed;
   ser_code_t  expQ[$];                        // expected answers in order

   ser_top #(.OQ_DEPTH(4)) uut (
      .clk_sys(clk_sys), .arst_n(arst_n), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdData(cmdData), .opsIdle(opsIdle), .execErr(execErr), .cmdErr(cmdErr),
      .errCode(errCode), .respRead(respRead), .respValid(respValid),
      .respData(respData), .statusByte(statusByte), .serviceRequest(serviceRequest));

   ser_host_model host (
      .clk_sys(clk_sys), .respValid(respValid), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdData(cmdData), .respRead(respRead));

   // 25 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic chkCode(input string what, input ser_code_t exp, input ser_code_t got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // each answer taken by the host is matched against the oldest note
   always @(posedge clk_sys) begin
      if (respRead === 1'b1 && respValid === 1'b1) begin
         if (expQ.size() == 0) chkCode("unexpected answer", 16'h7FFF, respData);
         else chkCode("respData", expQ.pop_front(), respData);
      end
   end

   // hang guard
   always @(posedge clk_sys) begin
      cycleCount++;
      if (cycleCount == 6000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic query(input ser_cmd_t op, input ser_code_t exp);
      expQ.push_back(exp);
      host.issue(op, 8'h00);
   endtask

   // one-cycle fault strobe with its code
   task automatic fault(input logic isExec, input ser_code_t code);
      @(negedge clk_sys);
      execErr = isExec;
      cmdErr  = !isExec;
      errCode = code;
      @(negedge clk_sys);
      execErr = 1'b0;
      cmdErr  = 1'b0;
      errCode = ~code;
   endtask

   task automatic drain;
      repeat (80) if (expQ.size() != 0) @(negedge clk_sys);
      chkByte("pending answers", 8'h00, 8'(expQ.size()));
      chkByte("respValid", 8'h00, {7'h00, respValid});
   endtask

   // main sequence
   initial begin
      arst_n = 1'b0; opsIdle = 1'b1; execErr = 1'b0; cmdErr = 1'b0; errCode = 16'h0000;
      n_mismatch = 0; checked = 0; cycleCount = 0;
      seed = $urandom(36510);
      cycles(2);
      arst_n = 1'b1;
      cycles(3);
      chkByte("statusByte", 8'h00, statusByte);
      host.issue(SER_CMD_ESE_WR, 8'h80);
      cycles(3);
      chkByte("statusByte", 8'h20, statusByte);
      host.issue(SER_CMD_SRE_WR, 8'h20);
      cycles(3);
      chkByte("statusByte", 8'h60, statusByte);
      chkByte("serviceRequest", 8'h01, {7'h00, serviceRequest});
      query(SER_CMD_STB_Q, 16'h0060);
      query(SER_CMD_ESR_Q, 16'h0080);
      query(SER_CMD_ESR_Q, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hFF : 8'($urandom);
         w = (i == 0) ? 8'hFF : 8'($urandom);
         host.issue(SER_CMD_SRE_WR, v);
         query(SER_CMD_SRE_Q, {8'h00, v & 8'h34});
         host.issue(SER_CMD_ESE_WR, w);
         query(SER_CMD_ESE_Q, {8'h00, w & 8'hB5});
      end
      drain();
      host.issue(SER_CMD_SRE_WR, 8'h04);
      host.issue(SER_CMD_ESE_WR, 8'h10);
      fault(1'b1, 16'hFF22);
      fault(1'b0, 16'hFF9A);
      cycles(3);
      chkByte("statusByte", 8'h64, statusByte);
      chkByte("serviceRequest", 8'h01, {7'h00, serviceRequest});
      query(SER_CMD_ESR_Q, 16'h0030);
      query(SER_CMD_ERR_Q, 16'hFF22);
      query(SER_CMD_ERR_Q, 16'hFF9A);
      query(SER_CMD_ERR_Q, SER_CODE_NOERR);
      host.issue(SER_CMD_SRE_WR, 8'h00);
      host.issue(SER_CMD_ESE_WR, 8'h00);
      drain();
      // operation complete waits for idle
      @(negedge clk_sys);
      opsIdle = 1'b0;
      host.issue(SER_CMD_OPC, 8'h00);
      cycles(4);
      query(SER_CMD_ESR_Q, 16'h0000);
      drain();
      opsIdle = 1'b1;
      cycles(3);
      query(SER_CMD_ESR_Q, 16'h0001);
      // error queue overflow: tenth code replaced by overflow report when the eleventh is lost
      for (int i = 0; i < 11; i++) fault(1'b1, 16'hFF38 - 16'(i));
      for (int i = 0; i < 9; i++) query(SER_CMD_ERR_Q, 16'hFF38 - 16'(i));
      query(SER_CMD_ERR_Q, SER_CODE_OVF);
      query(SER_CMD_ERR_Q, SER_CODE_NOERR);
      query(SER_CMD_ESR_Q, 16'h0010);
      drain();
      // output queue overflow with a stalled host
      host.slow = 1'b1;
      host.issue(SER_CMD_SRE_WR, 8'h10);
      repeat (4) query(SER_CMD_SRE_Q, 16'h0010);
      cycles(3);
      chkByte("statusByte", 8'h50, statusByte);
      chkByte("serviceRequest", 8'h01, {7'h00, serviceRequest});
      chkByte("respValid", 8'h01, {7'h00, respValid});
      host.issue(SER_CMD_SRE_Q, 8'h00);
      cycles(3);
      chkByte("statusByte", 8'h54, statusByte);
      host.slow = 1'b0;
      drain();
      query(SER_CMD_ESR_Q, 16'h0004);
      query(SER_CMD_ERR_Q, SER_CODE_OVF);
      drain();
      tally_and_finish();
   end
endmodule
